// file: design/gam_defines.svh
// gam_defines.svh: offsets, reset values and widths for the pin mux
// assumes: included by bare name from package and modules
`ifndef GAM_DEFINES_SVH
`define GAM_DEFINES_SVH
`define GAM_NPORT        8
`define GAM_SEL_NONE     8'h00
`define GAM_SEL_DIR      8'h01
`define GAM_SEL_PERIPH   8'h02
`define GAM_SEL_ODRAIN   8'h03
`define GAM_SEL_HIDRIVE  8'h04
`define GAM_SEL_WAKE     8'h05
`define GAM_RST_DIR      8'hFF
`define GAM_RST_ZERO     8'h00
`define GAM_PORT_A       3
`define GAM_PORT_A_IDX   3'h0
`define GAM_PORT_B_IDX   3'h1
`define GAM_PORT_C_IDX   3'h2
`define GAM_PORT_D_IDX   3'h3
`define GAM_PORT_H_IDX   3'h7
`define GAM_PORT_H_MASK  8'h0F
`define GAM_PORT_D_MASK  8'hFB
`endif

// file: design/gam_mux.sv
// gam_mux.sv: top of the pin alternate function mux, ports A to H
// assumes: pins are async; peripherals run on CLK_SYS
//
// Operation
// - per-pin select bit picks GPIO or peripheral
// - peripheral owns direction; direction bit ignored
// - port A carries timer, uart A, I2C
// - I2C pins forced open-drain
// - port C carries timers one, two, SPI
// - port D carries timer three, uart B, oscillator
// - ports E, F, G plain GPIO only
// - pin edges raise interrupt requests
// - four software registers per port
// - window reaches subregister named by selector
// - five configuration subregisters per port
// - selector codes one to five; others inert
// - direction 0 drives, 1 tristates and samples
`timescale 1ns/1ps
`include "gam_defines.svh"
module gam_mux (
  // clock, reset, enable
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  input  wire logic                    CE,
  // software access
  input  wire gam_pkg::gam_req_s       REQ,
  output logic [8*`GAM_NPORT-1:0]      SEL_RD,
  output logic [8*`GAM_NPORT-1:0]      WIN_RD,
  output logic [8*`GAM_NPORT-1:0]      IN_RD,
  output logic [8*`GAM_NPORT-1:0]      OUT_RD,
  // pins
  input  wire logic [8*`GAM_NPORT-1:0] PIN_I,
  output logic [8*`GAM_NPORT-1:0]      PIN_O,
  output logic [8*`GAM_NPORT-1:0]      PIN_OE,
  output logic [8*`GAM_NPORT-1:0]      PIN_HIDRIVE,
  output logic [8*`GAM_NPORT-1:0]      PIN_WAKE_EN,
  // peripheral side, ports A, C, D
  input  wire gam_pkg::gam_periph_s    PERIPH_A,
  input  wire gam_pkg::gam_periph_s    PERIPH_C,
  input  wire gam_pkg::gam_periph_s    PERIPH_D,
  output logic [7:0]                   PERIPH_IN_A,
  output logic [7:0]                   PERIPH_IN_C,
  output logic [7:0]                   PERIPH_IN_D,
  // analog select: B bits 0-7, H bits 8-11
  output logic [11:0]                  ANALOG_SEL,
  // interrupt edge selects and requests
  input  wire logic [8*`GAM_NPORT-1:0] EDGE_FALL_SEL,
  input  wire logic [8*`GAM_NPORT-1:0] EDGE_BOTH,
  output logic [8*`GAM_NPORT-1:0]      PIN_IRQ
);
  import gam_pkg::*;
  localparam int NP = `GAM_NPORT;
  logic [8*NP-1:0] s1_r, s2_r, s2d_r;
  logic [8*NP-1:0] sel_w, win_w, in_w, out_w, po_w, poe_w, hd_w, wk_w;
  logic [8*NP-1:0] irq_nxt;
  logic [8*NP-1:0] af_w;
  gam_periph_s     per_w [NP];
  default clocking cb_sys @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s2d_r <= '0;
    end else if (CE) begin
      s1_r  <= PIN_I;
      s2_r  <= s1_r;
      s2d_r <= s2_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // ports
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      localparam logic [7:0] AFM =
        (p == 0 || p == 1 || p == 2) ? 8'hFF :
        (p == 3) ? `GAM_PORT_D_MASK :
        (p == 7) ? `GAM_PORT_H_MASK : 8'h00;
      always_comb begin
        per_w[p] = '0;
        if (p == 0) per_w[p] = PERIPH_A;
        if (p == 2) per_w[p] = PERIPH_C;
        if (p == 3) per_w[p] = PERIPH_D;
      end
      gam_port #(.AF_MASK(AFM), .I2C_OD(p == 0)) u_port (
        .clk          (CLK_SYS),
        .rst          (RST),
        .ce           (CE),
        .wr_sel       (REQ.wr_sel && REQ.port == p),
        .wr_win       (REQ.wr_win && REQ.port == p),
        .wr_out       (REQ.wr_out && REQ.port == p),
        .wdata        (REQ.wdata),
        .pin_sync     (s2_r[8*p +: 8]),
        .periph_drive (per_w[p].drive),
        .periph_oe    (per_w[p].oe),
        .sel_q        (sel_w[8*p +: 8]),
        .win_q        (win_w[8*p +: 8]),
        .in_q         (in_w[8*p +: 8]),
        .out_q        (out_w[8*p +: 8]),
        .pin_o        (po_w[8*p +: 8]),
        .pin_oe       (poe_w[8*p +: 8]),
        .hidrive      (hd_w[8*p +: 8]),
        .wake_en      (wk_w[8*p +: 8]),
        .af_q         (af_w[8*p +: 8])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // edge requests
  always_comb begin
    for (int k = 0; k < 8*NP; k++) begin
      if (EDGE_BOTH[k])
        irq_nxt[k] = s2_r[k] ^ s2d_r[k];
      else if (EDGE_FALL_SEL[k])
        irq_nxt[k] = s2d_r[k] & ~s2_r[k];
      else
        irq_nxt[k] = s2_r[k] & ~s2d_r[k];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SEL_RD      <= '0;
      WIN_RD      <= '0;
      IN_RD       <= '0;
      OUT_RD      <= '0;
      PIN_O       <= '0;
      PIN_OE      <= '0;
      PIN_HIDRIVE <= '0;
      PIN_WAKE_EN <= '0;
      PERIPH_IN_A <= '0;
      PERIPH_IN_C <= '0;
      PERIPH_IN_D <= '0;
      ANALOG_SEL  <= '0;
      PIN_IRQ     <= '0;
    end else if (CE) begin
      SEL_RD      <= sel_w;
      WIN_RD      <= win_w;
      IN_RD       <= in_w;
      OUT_RD      <= out_w;
      PIN_O       <= po_w;
      PIN_OE      <= poe_w;
      PIN_HIDRIVE <= hd_w;
      PIN_WAKE_EN <= wk_w;
      PERIPH_IN_A <= s2_r[7:0];
      PERIPH_IN_C <= s2_r[23:16];
      PERIPH_IN_D <= s2_r[31:24];
      ANALOG_SEL  <= {af_w[59:56], af_w[15:8]};
      PIN_IRQ     <= irq_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_i2c_open_drain: assert property (
    CE && af_w[6] |=> !PIN_O[6])
    else $error("i2c clock pin driven high");
  chk_dir_tristate: assert property (
    CE && !af_w[32] && g_port[4].u_port.dir_r[0] |=> !PIN_OE[32])
    else $error("input pin driven");
  chk_plain_port: assert property (
    af_w[55:32] == 24'h000000)
    else $error("plain port has peripheral");
  chk_inert_sel: assert property (
    CE && REQ.wr_win && REQ.port == 3'h0
    && g_port[0].u_port.sel_r == 8'h00
    |=> $stable({g_port[0].u_port.dir_r, g_port[0].u_port.periph_r,
                 g_port[0].u_port.od_r, g_port[0].u_port.hd_r,
                 g_port[0].u_port.wake_r}))
    else $error("window write with inert selector");
  chk_rise_irq: assert property (
    CE && $past(CE) && !EDGE_BOTH[0] && !EDGE_FALL_SEL[0] && s2_r[0]
    && !s2d_r[0] |=> PIN_IRQ[0])
    else $error("rising edge request missing");
  chk_fall_irq: assert property (
    CE && !EDGE_BOTH[8] && EDGE_FALL_SEL[8] && !s2_r[8] && s2d_r[8]
    |=> PIN_IRQ[8])
    else $error("falling edge request missing");
  chk_both_irq: assert property (
    CE && EDGE_BOTH[16] && s2_r[16] != s2d_r[16] |=> PIN_IRQ[16])
    else $error("any edge request missing");
  chk_periph_dir: assert property (
    CE && af_w[19] && !g_port[2].u_port.od_r[3]
    |=> PIN_OE[19] == $past(PERIPH_C.oe[3]))
    else $error("peripheral direction not obeyed");
  chk_gpio_drive: assert property (
    CE && !af_w[16] && !g_port[2].u_port.od_r[0]
    |=> PIN_O[16] == $past(g_port[2].u_port.out_r[0]))
    else $error("gpio drive wrong");
  chk_port_a_uart: assert property (
    CE && af_w[5] && !g_port[0].u_port.od_r[5]
    |=> PIN_O[5] == $past(PERIPH_A.drive[5]))
    else $error("uart a transmit not routed");
  chk_port_d_gap: assert property (
    !af_w[26])
    else $error("port d bit 2 has peripheral");
  chk_port_d_osc: assert property (
    CE && af_w[31] && !g_port[3].u_port.od_r[7]
    |=> PIN_O[31] == $past(PERIPH_D.drive[7]))
    else $error("oscillator output not routed");
  chk_analog_map: assert property (
    CE |=> ANALOG_SEL == $past({g_port[7].u_port.periph_r[3:0],
                                g_port[1].u_port.periph_r}))
    else $error("analog select mismatch");
  chk_sel_readback: assert property (
    CE && REQ.wr_sel && REQ.port == 3'h2 ##1 CE
    |=> SEL_RD[23:16] == $past(REQ.wdata, 2))
    else $error("selector readback wrong");
  chk_win_route: assert property (
    CE && REQ.wr_win && REQ.port == 3'h1 && g_port[1].u_port.sel_r == 8'h04
    |=> g_port[1].u_port.hd_r == $past(REQ.wdata))
    else $error("window write missed high drive");
  chk_dir_output: assert property (
    CE && !g_port[5].u_port.dir_r[0] && !g_port[5].u_port.od_r[0]
    |=> PIN_OE[40])
    else $error("output pin not driven");
  cov_af_sel: cover property (REQ.wr_win && SEL_RD[7:0] == 8'h02);
  cov_irq: cover property (|PIN_IRQ);
  cov_i2c: cover property (af_w[7]);
  cov_inert_write: cover property (
    REQ.wr_win && REQ.port == 3'h0 && g_port[0].u_port.sel_r == 8'h00);
  cov_ce_hold: cover property (!CE && REQ.wr_out);
endmodule

// file: design/gam_pkg.sv
// gam_pkg.sv: types shared by the pin mux modules
// assumes: gam_defines.svh on the include path
`include "gam_defines.svh"
package gam_pkg;
  typedef logic [7:0] gam_byte_t;
  // software access to one port's register group
  typedef struct packed {
    logic [2:0] port;
    logic       wr_sel;
    logic       wr_win;
    logic       wr_out;
    logic [7:0] wdata;
  } gam_req_s;
  // per-pin peripheral hookup for one port
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
  } gam_periph_s;
  typedef enum logic [1:0] {
    GAM_EDGE_RISE = 2'b00,
    GAM_EDGE_FALL = 2'b01,
    GAM_EDGE_BOTH = 2'b11
  } gam_edge_e;
endpackage

// file: design/gam_port.sv
// gam_port.sv: one port's configuration and pin drive
// assumes: pin input already synchronised; single clock domain
`timescale 1ns/1ps
`include "gam_defines.svh"
module gam_port #(
  parameter logic [7:0] AF_MASK = 8'hFF,
  parameter bit         I2C_OD  = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wr_sel,
  input  wire logic       wr_win,
  input  wire logic       wr_out,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] pin_sync,
  input  wire logic [7:0] periph_drive,
  input  wire logic [7:0] periph_oe,
  output logic      [7:0] sel_q,
  output logic      [7:0] win_q,
  output logic      [7:0] in_q,
  output logic      [7:0] out_q,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe,
  output logic      [7:0] hidrive,
  output logic      [7:0] wake_en,
  output logic      [7:0] af_q
);
  logic [7:0] dir_r, periph_r, od_r, hd_r, wake_r, sel_r, out_r, in_r;
  logic [7:0] af_eff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sel_r <= `GAM_RST_ZERO;
    else if (ce && wr_sel) sel_r <= wdata;
  end
  // indirect window writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_r    <= `GAM_RST_DIR;
      periph_r <= `GAM_RST_ZERO;
      od_r     <= `GAM_RST_ZERO;
      hd_r     <= `GAM_RST_ZERO;
      wake_r   <= `GAM_RST_ZERO;
    end else if (ce && wr_win) begin
      case (sel_r)
        `GAM_SEL_DIR:     dir_r    <= wdata;
        `GAM_SEL_PERIPH:  periph_r <= wdata;
        `GAM_SEL_ODRAIN:  od_r     <= wdata;
        `GAM_SEL_HIDRIVE: hd_r     <= wdata;
        `GAM_SEL_WAKE:    wake_r   <= wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) out_r <= `GAM_RST_ZERO;
    else if (ce && wr_out) out_r <= wdata;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) in_r <= `GAM_RST_ZERO;
    else if (ce) in_r <= pin_sync;
  end
  assign af_eff = periph_r & AF_MASK;
  always_comb begin
    case (sel_r)
      `GAM_SEL_DIR:     win_q = dir_r;
      `GAM_SEL_PERIPH:  win_q = periph_r;
      `GAM_SEL_ODRAIN:  win_q = od_r;
      `GAM_SEL_HIDRIVE: win_q = hd_r;
      `GAM_SEL_WAKE:    win_q = wake_r;
      default:          win_q = `GAM_RST_ZERO;
    endcase
  end
  // per-pin drive choice
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic d, e, od;
      always_comb begin
        od = od_r[i] | (I2C_OD && i >= 6 && af_eff[i]);
        if (af_eff[i]) begin
          d = periph_drive[i];
          e = periph_oe[i];
        end else begin
          d = out_r[i];
          e = ~dir_r[i];
        end
        pin_o[i]  = od ? 1'b0 : d;
        pin_oe[i] = od ? (e & ~d) : e;
      end
    end
  endgenerate
  assign sel_q   = sel_r;
  assign in_q    = in_r;
  assign out_q   = out_r;
  assign hidrive = hd_r;
  assign wake_en = wake_r;
  assign af_q    = af_eff;
endmodule

// file: dv/gam_pin_model.sv
// gam_pin_model.sv: pins and peripherals outside the mux
// assumes: undriven pins follow the external value
`timescale 1ns/1ps
module gam_pin_model
  import gam_pkg::*;
(
  // far side stimulus
  input  wire logic [63:0] ext,
  input  wire logic [47:0] prnd,
  // mux pin drive
  input  wire logic [63:0] pin_o,
  input  wire logic [63:0] pin_oe,
  // resolved pins, peripheral drive
  output logic [63:0]      pin_i,
  output gam_periph_s      pa,
  output gam_periph_s      pc,
  output gam_periph_s      pd
);
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext[i];
    end
  end
  // i2c master always enables its drive
  assign pa = {prnd[7:0], prnd[15:8] | 8'hC0};
  assign pc = prnd[31:16];
  assign pd = prnd[47:32];
endmodule

// file: dv/test_gpio_alternate_function_mux.sv
// test_gpio_alternate_function_mux.sv: self-checking bench for gam_mux
// assumes: gam_pkg compiled first
`timescale 1ns/1ps
module test_gpio_alternate_function_mux;
  import gam_pkg::*;
  logic clk, rst, ce;
  gam_req_s req;
  logic [63:0] sel_rd, win_rd, in_rd, out_rd, pin_i, pin_o, pin_oe;
  logic [63:0] hid, wak, ext, efall, eboth, irq, irqs, eo, eoe, old, ei;
  gam_periph_s pa, pc, pd;
  logic [7:0] pia, pic, pid, v, c;
  logic [11:0] ana;
  logic [47:0] prnd;
  logic [31:0] rs, t;
  logic [7:0] sub[8][6];
  logic [7:0] outv[8];
  logic [7:0] mask[8];
  int n_fail, checks_done;
  ////////////////////////////////////////////////////////////////////
  gam_mux uut (.CLK_SYS(clk), .RST(rst), .CE(ce), .REQ(req),
    .SEL_RD(sel_rd), .WIN_RD(win_rd), .IN_RD(in_rd), .OUT_RD(out_rd),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_HIDRIVE(hid),
    .PIN_WAKE_EN(wak), .PERIPH_A(pa), .PERIPH_C(pc), .PERIPH_D(pd),
    .PERIPH_IN_A(pia), .PERIPH_IN_C(pic), .PERIPH_IN_D(pid),
    .ANALOG_SEL(ana), .EDGE_FALL_SEL(efall), .EDGE_BOTH(eboth),
    .PIN_IRQ(irq));
  gam_pin_model far (.ext(ext), .prnd(prnd), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_i(pin_i), .pa(pa), .pc(pc), .pd(pd));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd;
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] p, input logic [2:0] k,
                    input logic [7:0] d);
    @(negedge clk);
    req = '{port: p, wr_sel: k[0], wr_win: k[1], wr_out: k[2], wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic calc;
    logic d, o, a;
    int p, b;
    for (int i = 0; i < 64; i++) begin
      p = i / 8;
      b = i % 8;
      a = sub[p][2][b] & mask[p][b];
      d = p == 0 ? pa.drive[b] : p == 2 ? pc.drive[b] :
          p == 3 ? pd.drive[b] : 1'b0;
      o = p == 0 ? pa.oe[b] : p == 2 ? pc.oe[b] : p == 3 ? pd.oe[b] : 1'b0;
      if (a && p == 0 && b > 5) begin
        eo[i] = 1'b0;
        eoe[i] = o & ~d;
      end else if (a) begin
        eo[i] = d;
        eoe[i] = o;
      end else begin
        eo[i] = sub[p][3][b] ? 1'b0 : outv[p][b];
        eoe[i] = ~sub[p][1][b] & (~sub[p][3][b] | ~outv[p][b]);
      end
    end
  endtask
  task automatic chk_pins;
    calc();
    chk(pin_oe, eoe);
    chk(pin_o & eoe, eo & eoe);
    chk(pin_o[7:6] & sub[0][2][7:6], 64'h0);
    chk(pin_oe[23:16], eoe[23:16]);
    chk(pin_oe[31:24], eoe[31:24]);
    chk(pin_oe[55:32], eoe[55:32]);
    chk(in_rd & ~eoe, pin_i & ~eoe);
    chk({pid, pic, pia}, {pin_i[31:24], pin_i[23:16], pin_i[7:0]});
    chk(ana, {sub[7][2][3:0] & mask[7][3:0], sub[1][2]});
    for (int p = 0; p < 8; p++) begin
      chk(hid[8*p+:8], sub[p][4]);
      chk(wak[8*p+:8], sub[p][5]);
      chk(out_rd[8*p+:8], outv[p]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1; ce = 1'b1; req = '0; ext = '0; efall = '0; eboth = '0;
    prnd = '0; rs = 32'h65B5; n_fail = 0; checks_done = 0;
    mask = '{8'hFF, 8'hFF, 8'hFF, 8'hFB, 8'h00, 8'h00, 8'h00, 8'h0F};
    for (int p = 0; p < 8; p++) begin
      for (int s = 0; s < 6; s++) sub[p][s] = s == 1 ? 8'hFF : 8'h00;
      outv[p] = 8'h00;
    end
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wait_n(4);
    chk(pin_oe, 64'h0);
    chk(sel_rd, 64'h0);
    for (int r = 0; r < 4; r++) begin
      t = rnd();
      prnd = {t[15:0], rnd()};
      for (int p = 0; p < 8; p++) begin
        for (int s = 1; s < 6; s++) begin
          t = rnd();
          v = s == 3 ? t[7:0] & ~sub[p][2] : t[7:0];
          wr(3'(p), 3'b001, 8'(s));
          wr(3'(p), 3'b010, v);
          sub[p][s] = v;
          wait_n(3);
          chk(sel_rd[8*p+:8], 8'(s));
          chk(win_rd[8*p+:8], sub[p][s]);
        end
        t = rnd();
        wr(3'(p), 3'b100, t[7:0]);
        outv[p] = t[7:0];
      end
      c = r == 0 ? 8'h00 : r == 1 ? 8'h06 : 8'hFF;
      wr(3'(r), 3'b001, c);
      wr(3'(r), 3'b010, 8'hA5);
      wait_n(3);
      chk(sel_rd[8*r+:8], c);
      wr(3'(r), 3'b011, 8'h01);
      wait_n(3);
      chk(win_rd[8*r+:8], sub[r][1]);
      wait_n(8);
      chk_pins();
      efall = {rnd(), rnd()};
      eboth = {rnd(), rnd()};
      wait_n(8);
      old = pin_i;
      ext = {rnd(), rnd()};
      irqs = '0;
      repeat (8) begin
        @(negedge clk);
        irqs = irqs | irq;
      end
      for (int i = 0; i < 64; i++) begin
        ei[i] = eboth[i] ? old[i] ^ pin_i[i] :
                efall[i] ? old[i] & ~pin_i[i] : ~old[i] & pin_i[i];
      end
      chk(irqs, ei);
      ce = 1'b0;
      wr(3'h0, 3'b100, ~outv[0]);
      wait_n(2);
      ce = 1'b1;
      wait_n(3);
      chk(out_rd[7:0], outv[0]);
    end
    report_and_stop();
  end
endmodule
